// ==== ssr_pkg.sv ====
// Purpose: Types shared by the supply supervisor files.
// Assumes: ssr_regs.svh supplies the widths.
// Notes:   Comparator bits are high while the supply is above the threshold.
`include "ssr_regs.svh"

package ssr_pkg;

	// ======================================================================
	// Analog comparator results
	typedef struct packed {
		logic [`SSR_PVD_LEVELS-1:0] pvd_above;
		logic [`SSR_BOR_LEVELS-1:0] bor_rise_above;
		logic [`SSR_BOR_LEVELS-1:0] bor_fall_above;
		logic                       pon_above;
		logic                       pdr_above;
		logic                       por_above;
	} ssr_cmp_t;

	// ======================================================================
	// Same-domain reset requests, each high while requesting
	typedef struct packed {
		logic windowed_watchdog;
		logic independent_watchdog;
		logic software_reset_request;
		logic low_power_entry;
		logic option_loader;
		logic standby_exit;
	} ssr_src_t;

	// ======================================================================
	// Sticky reset-source flags
	typedef struct packed {
		logic power;
		logic external_reset_pin;
		logic windowed_watchdog;
		logic independent_watchdog;
		logic software_reset_request;
		logic low_power_entry;
		logic option_loader;
		logic standby_exit;
	} ssr_flags_t;

	// ======================================================================
	// Brownout guard option byte settings
	typedef struct packed {
		logic                      disable_guard;
		logic [`SSR_BOR_LVL_W-1:0] level;
	} ssr_opt_t;

	typedef enum logic [1:0] {
		PVD_EDGE_FALL = 2'b00,
		PVD_EDGE_RISE = 2'b01,
		PVD_EDGE_BOTH = 2'b10
	} ssr_pvd_mode_t;

	typedef enum logic [1:0] {
		PWR_OFF    = 2'b00,
		PWR_SETTLE = 2'b01,
		PWR_RUN    = 2'b10
	} ssr_pwr_state_t;

endpackage : ssr_pkg

// ==== ssr_regs.svh ====
// Purpose: Constants for the supply supervisor and reset controller.
// Assumes: Voltages in millivolts, times in microseconds, rates in hertz.
// Notes:   Included by the package, the supervisor module and the supply model.
`ifndef SSR_REGS_SVH
`define SSR_REGS_SVH

// ==========================================================================
// Brownout guard
`define SSR_BOR_LEVELS     5
`define SSR_BOR_LVL_W      3
`define SSR_BOR_LVL_DEF    3'h4
`define SSR_BOR_LVL_MAX    3'h4
`define SSR_BOR_PON_MV     1800
`define SSR_PDR_LOW_MV     1650

// ==========================================================================
// Supply-level detector
`define SSR_PVD_LEVELS     7
`define SSR_PVD_LVL_W      3
`define SSR_PVD_LVL_MAX    3'h6
`define SSR_PVD_MIN_MV     1850
`define SSR_PVD_STEP_MV    200
`define SSR_PVD_MAX_MV     3050

// ==========================================================================
// Power-up settling delay, counted in low-speed clock edges
`define SSR_SETTLE_US      1000
`define SSR_LS_CLK_HZ      37000
`define SSR_SETTLE_TICKS   ((`SSR_SETTLE_US * `SSR_LS_CLK_HZ) / 1000000)
`define SSR_SETTLE_CNT_W   16

// ==========================================================================
// Reset value and synchroniser width
`define SSR_FLAGS_RST      8'h80
`define SSR_SYNC_W         22

`endif

// ==== ssr_supervisor.sv ====
// Purpose: Supply supervision, brownout guard and system reset merge.
// Assumes: i_reset_n is the always-on reset, released once at power-on.
// Notes:   Comparators, pin and low-speed clock are synchronised here.
`timescale 1ns/1ps
`include "ssr_regs.svh"

module ssr_supervisor
	import ssr_pkg::*;
#(
	parameter int unsigned SETTLE_TICKS = `SSR_SETTLE_TICKS
)
(
	input  wire logic                      i_clk,
	input  wire logic                      i_reset_n,
	input  wire logic                      i_ls_clk,
	input  wire logic                      i_has_bor,
	input  wire ssr_cmp_t                  i_cmp,
	input  wire logic                      i_ext_rst_n,
	input  wire ssr_src_t                  i_src,
	input  wire logic                      i_opt_load,
	input  wire ssr_opt_t                  i_opt,
	input  wire logic                      i_pvd_en,
	input  wire logic [`SSR_PVD_LVL_W-1:0] i_pvd_lvl,
	input  wire ssr_pvd_mode_t             i_pvd_mode,
	input  wire logic                      i_flag_clr,
	output logic                           o_sys_reset_n,
	output logic                           o_por_reset_n,
	output logic                           o_pvd_irq,
	output logic                           o_pvd_above,
	output ssr_flags_t                     o_rst_flags,
	output ssr_opt_t                       o_bor_cfg,
	output logic                           o_bor_active
);

	// ======================================================================
	// Input synchronisation
	logic [`SSR_SYNC_W-1:0] sync_in;
	logic [`SSR_SYNC_W-1:0] sync_out;
	ssr_cmp_t               cmp;
	logic                   ext_low;
	logic                   ls_lvl;

	// Pin goes in inverted so a cleared synchroniser reads as released, not pressed
	assign sync_in = {i_ls_clk, ~i_ext_rst_n, i_cmp};

	ssr_sync #(
		.W (`SSR_SYNC_W)
	) u_sync (
		.i_clk     (i_clk),
		.i_reset_n (i_reset_n),
		.i_async   (sync_in),
		.o_level   (sync_out)
	);

	// Comparators clear to below, so the supply counts as lost until it settles
	assign cmp     = ssr_cmp_t'(sync_out[`SSR_SYNC_W-3:0]);
	assign ext_low = sync_out[`SSR_SYNC_W-2];
	assign ls_lvl  = sync_out[`SSR_SYNC_W-1];

	// ======================================================================
	// Brownout guard configuration
	logic     opt_loaded_q;
	logic     opt_loaded_d;
	ssr_opt_t opt_q;
	ssr_opt_t opt_d;
	logic     sys_rst_q;
	logic     sys_rst_d;
	ssr_pwr_state_t state_q;
	ssr_pwr_state_t state_d;

	always_comb
	begin
		opt_loaded_d = opt_loaded_q;
		opt_d        = opt_q;
		if (state_q == PWR_OFF)
		begin
			// Power loss returns to power-on defaults
			opt_loaded_d        = 1'b0;
			opt_d.disable_guard = 1'b0;
			opt_d.level         = `SSR_BOR_LVL_DEF;
		end
		else if (i_opt_load && !sys_rst_q)
		begin
			opt_loaded_d        = 1'b1;
			opt_d.disable_guard = i_opt.disable_guard;
			opt_d.level         = (i_opt.level > `SSR_BOR_LVL_MAX) ? `SSR_BOR_LVL_MAX
			                                                      : i_opt.level;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			opt_loaded_q        <= 1'b0;
			opt_q.disable_guard <= 1'b0;
			opt_q.level         <= `SSR_BOR_LVL_DEF;
		end
		else
		begin
			opt_loaded_q <= opt_loaded_d;
			opt_q        <= opt_d;
		end
	end

	// ======================================================================
	// Supply qualification
	logic bor_on;
	logic rise_ok;
	logic fall_ok;
	logic supply_ok;
	logic ok_q;

	always_comb
	begin
		// Guard on before options are loaded whenever i_has_bor is set; 1.8 V comparator rules then
		bor_on  = i_has_bor && !(opt_loaded_q && opt_q.disable_guard);
		rise_ok = cmp.pon_above;
		fall_ok = cmp.pon_above;
		if (opt_loaded_q)
		begin
			rise_ok = cmp.bor_rise_above[opt_q.level];
			fall_ok = cmp.bor_fall_above[opt_q.level];
		end
		if (bor_on)
		begin
			// Hysteresis: stay up on the lower limit, come up on the upper one
			supply_ok = ok_q ? fall_ok : rise_ok;
		end
		else
		begin
			supply_ok = ok_q ? cmp.pdr_above : cmp.por_above;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			ok_q <= 1'b0;
		end
		else
		begin
			ok_q <= supply_ok;
		end
	end

	// ======================================================================
	// Power state and settling delay
	logic                         ls_prev_q;
	logic                         ls_edge;
	logic [`SSR_SETTLE_CNT_W-1:0] cnt_q;
	logic [`SSR_SETTLE_CNT_W-1:0] cnt_d;
	localparam logic [`SSR_SETTLE_CNT_W-1:0] SETTLE_LAST =
		(SETTLE_TICKS > 1) ? `SSR_SETTLE_CNT_W'(SETTLE_TICKS - 1) : '0;

	assign ls_edge = ls_lvl && !ls_prev_q;

	always_comb
	begin
		state_d = state_q;
		cnt_d   = cnt_q;
		case (state_q)
			PWR_OFF:
			begin
				cnt_d = '0;
				if (supply_ok)
				begin
					state_d = PWR_SETTLE;
				end
			end
			PWR_SETTLE:
			begin
				if (!supply_ok)
				begin
					state_d = PWR_OFF;
				end
				else if (ls_edge)
				begin
					if (cnt_q == SETTLE_LAST)
					begin
						state_d = PWR_RUN;
					end
					cnt_d = cnt_q + 1'b1;
				end
			end
			PWR_RUN:
			begin
				if (!supply_ok)
				begin
					state_d = PWR_OFF;
				end
			end
			default:
			begin
				state_d = PWR_OFF;
			end
		endcase
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			state_q   <= PWR_OFF;
			cnt_q     <= '0;
			ls_prev_q <= 1'b0;
		end
		else
		begin
			state_q   <= state_d;
			cnt_q     <= cnt_d;
			ls_prev_q <= ls_lvl;
		end
	end

	// ======================================================================
	// System reset merge and source flags
	ssr_flags_t flags_q;
	ssr_flags_t flags_d;
	ssr_flags_t flag_set;

	always_comb
	begin
		flag_set.power                  = (state_q != PWR_RUN);
		flag_set.external_reset_pin     = ext_low;
		flag_set.windowed_watchdog      = i_src.windowed_watchdog;
		flag_set.independent_watchdog   = i_src.independent_watchdog;
		flag_set.software_reset_request = i_src.software_reset_request;
		flag_set.low_power_entry        = i_src.low_power_entry;
		flag_set.option_loader          = i_src.option_loader;
		flag_set.standby_exit           = i_src.standby_exit;
		sys_rst_d = |flag_set;
		// A source in the clearing cycle survives the clear
		flags_d = (i_flag_clr ? ssr_flags_t'('0) : flags_q) | flag_set;
	end

	// Flags answer only to the always-on reset, never to the system reset
	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			flags_q   <= `SSR_FLAGS_RST;
			sys_rst_q <= 1'b1;
		end
		else
		begin
			flags_q   <= flags_d;
			sys_rst_q <= sys_rst_d;
		end
	end

	// ======================================================================
	// Supply-level detector
	logic [`SSR_PVD_LVL_W-1:0] pvd_sel;
	logic                      pvd_now;
	logic                      pvd_prev_q;
	logic                      pvd_prev_d;
	logic                      pvd_irq_q;
	logic                      pvd_irq_d;
	logic                      pvd_above_q;
	logic                      pvd_above_d;

	always_comb
	begin
		pvd_sel = (i_pvd_lvl > `SSR_PVD_LVL_MAX) ? `SSR_PVD_LVL_MAX : i_pvd_lvl;
		pvd_now = cmp.pvd_above[pvd_sel];
		pvd_irq_d   = 1'b0;
		pvd_above_d = 1'b0;
		// While disabled the history tracks, so enabling gives no false edge
		pvd_prev_d  = pvd_now;
		if (i_pvd_en)
		begin
			pvd_above_d = pvd_now;
			case (i_pvd_mode)
				PVD_EDGE_FALL: pvd_irq_d = pvd_prev_q && !pvd_now;
				PVD_EDGE_RISE: pvd_irq_d = !pvd_prev_q && pvd_now;
				PVD_EDGE_BOTH: pvd_irq_d = pvd_prev_q ^ pvd_now;
				default:       pvd_irq_d = 1'b0;
			endcase
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			pvd_prev_q  <= 1'b0;
			pvd_irq_q   <= 1'b0;
			pvd_above_q <= 1'b0;
		end
		else
		begin
			pvd_prev_q  <= pvd_prev_d;
			pvd_irq_q   <= pvd_irq_d;
			pvd_above_q <= pvd_above_d;
		end
	end

	// ======================================================================
	// Outputs
	assign o_sys_reset_n = ~sys_rst_q;
	assign o_por_reset_n = ok_q && (state_q == PWR_RUN);
	assign o_pvd_irq     = pvd_irq_q;
	assign o_pvd_above   = pvd_above_q;
	assign o_rst_flags   = flags_q;
	assign o_bor_cfg     = opt_q;
	assign o_bor_active  = bor_on;

endmodule : ssr_supervisor

// ==== ssr_supervisor_props.sv ====
// Purpose: Port-level assertions for the supervisor.
// Assumes: One clock domain, synchronous reset.
// Notes:   Windows allow for the four-flop input synchroniser.
`timescale 1ns/1ps

module ssr_supervisor_props
	import ssr_pkg::*;
#(
	parameter int unsigned SETTLE_TICKS = 2
)
(
	input wire logic          i_clk,
	input wire logic          i_reset_n,
	input wire logic          i_has_bor,
	input wire logic          i_ext_rst_n,
	input wire ssr_src_t      i_src,
	input wire logic          i_opt_load,
	input wire ssr_opt_t      i_opt,
	input wire logic          i_pvd_en,
	input wire ssr_pvd_mode_t i_pvd_mode,
	input wire logic          i_flag_clr,
	input wire logic          o_sys_reset_n,
	input wire logic          o_por_reset_n,
	input wire logic          o_pvd_irq,
	input wire logic          o_pvd_above,
	input wire ssr_flags_t    o_rst_flags,
	input wire ssr_opt_t      o_bor_cfg,
	input wire logic          o_bor_active
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	// ======================================================================
	// Pin reset steps
	sequence pin_held_s;
		!i_ext_rst_n [*5];
	endsequence
	sequence pin_seen_s;
		##[0:4] (!o_sys_reset_n && o_rst_flags.external_reset_pin);
	endsequence

	pin_reset_a: assert property (pin_held_s |-> pin_seen_s)
		else $error("pin low without reset");
	src_reset_a: assert property ((|i_src) |=> !o_sys_reset_n)
		else $error("source without reset");
	src_flag_a: assert property ((|i_src) |=> ((o_rst_flags[5:0] & $past(i_src)) == $past(i_src)))
		else $error("source flag missing");
	flag_sticky_a: assert property (!i_flag_clr |=> ((o_rst_flags & $past(o_rst_flags)) == $past(o_rst_flags)))
		else $error("flag lost");
	flag_clear_a: assert property ((i_flag_clr && i_src == '0) |=> o_rst_flags[5:0] == 6'h00)
		else $error("flags not cleared");
	opt_take_a: assert property ((i_opt_load && o_sys_reset_n) |=> (o_bor_cfg.disable_guard == $past(i_opt.disable_guard) && o_bor_cfg.level == ($past(i_opt.level) > 3'h4 ? 3'h4 : $past(i_opt.level))))
		else $error("option not taken");
	opt_refuse_a: assert property ((i_opt_load && !o_sys_reset_n && o_por_reset_n) |=> $stable(o_bor_cfg))
		else $error("option taken in reset");
	guard_on_a: assert property (o_bor_active == (i_has_bor && !o_bor_cfg.disable_guard))
		else $error("guard state wrong");
	settle_first_a: assert property ($rose(o_sys_reset_n) |-> (o_por_reset_n && $past(o_por_reset_n)))
		else $error("release before settle");
	irq_pulse_a: assert property (o_pvd_irq |=> !o_pvd_irq)
		else $error("irq longer than a cycle");
	pvd_quiet_a: assert property (!i_pvd_en |=> (!o_pvd_irq && !o_pvd_above))
		else $error("detector active when off");
	rise_edge_a: assert property ((o_pvd_irq && $past(i_pvd_mode) == PVD_EDGE_RISE) |-> o_pvd_above)
		else $error("rise irq while below");
endmodule : ssr_supervisor_props

bind ssr_supervisor ssr_supervisor_props #(.SETTLE_TICKS(SETTLE_TICKS)) ssr_supervisor_props_i (
	.i_clk, .i_reset_n, .i_has_bor, .i_ext_rst_n, .i_src, .i_opt_load, .i_opt, .i_pvd_en,
	.i_pvd_mode, .i_flag_clr, .o_sys_reset_n, .o_por_reset_n, .o_pvd_irq, .o_pvd_above,
	.o_rst_flags, .o_bor_cfg, .o_bor_active);

// ==== ssr_supply_model.sv ====
// Purpose: Comparator and reset pin model for the supervisor.
// Assumes: Supply level given in millivolts.
// Notes:   Guard levels are plain defaults; the pin has a pull-up.
`timescale 1ns/1ps
`include "ssr_regs.svh"

module ssr_supply_model
	import ssr_pkg::*;
#(
	parameter int BOR_MV  = 1800,
	parameter int STEP_MV = 200,
	parameter int HYST_MV = 100,
	parameter int PDR_MV  = 1500
)
(
	input  wire logic [15:0] i_mv,
	input  wire logic        i_press,
	output ssr_cmp_t         o_cmp,
	output logic             o_ext_rst_n
);
	// ======================================================================
	// Comparators, high while the supply is above
	always_comb
	begin
		for (int k = 0; k < `SSR_PVD_LEVELS; k++)
			o_cmp.pvd_above[k] = i_mv > `SSR_PVD_MIN_MV + k * `SSR_PVD_STEP_MV;
		for (int k = 0; k < `SSR_BOR_LEVELS; k++)
		begin
			o_cmp.bor_rise_above[k] = i_mv > BOR_MV + k * STEP_MV;
			o_cmp.bor_fall_above[k] = i_mv > BOR_MV + k * STEP_MV - HYST_MV;
		end
		o_cmp.pon_above = i_mv > `SSR_BOR_PON_MV;
		o_cmp.pdr_above = i_mv > PDR_MV;
		o_cmp.por_above = i_mv > PDR_MV;
	end
	// Released pin is pulled high, never left at its last value
	assign o_ext_rst_n = i_press ? 1'b0 : 1'b1;
endmodule : ssr_supply_model

// ==== ssr_sync.sv ====
// Purpose: Three-stage input synchroniser with agreement filter.
// Assumes: Inputs are asynchronous levels.
// Notes:   Output follows only once stages two and three agree.
`timescale 1ns/1ps

module ssr_sync
#(
	parameter int unsigned W = 1
)
(
	input  wire logic         i_clk,
	input  wire logic         i_reset_n,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_level
);

	// ======================================================================
	// Stages
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] out_q;
	logic [W-1:0] out_d;

	always_comb
	begin
		// Per bit, so one noisy comparator cannot hold back the others
		out_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & out_q);
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			s1_q  <= '0;
			s2_q  <= '0;
			s3_q  <= '0;
			out_q <= '0;
		end
		else
		begin
			s1_q  <= i_async;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			out_q <= out_d;
		end
	end

	assign o_level = out_q;

endmodule : ssr_sync

// ==== tb.sv ====
// Purpose: Self-checking bench for the supervisor.
// Assumes: Short settle count; low-speed clock free running.
// Notes:   Interrupts are matched against a queue of expectations.
`timescale 1ns/1ps

module tb
	import ssr_pkg::*;
;
	logic i_clk, i_reset_n, i_ls_clk, i_has_bor, i_ext_rst_n, i_opt_load, i_pvd_en, i_flag_clr;
	logic o_sys_reset_n, o_por_reset_n, o_pvd_irq, o_pvd_above, o_bor_active, press;
	logic [2:0] i_pvd_lvl, lv;
	logic [15:0] mv;
	ssr_src_t i_src;
	ssr_opt_t i_opt, o_bor_cfg;
	ssr_cmp_t i_cmp;
	ssr_flags_t o_rst_flags;
	ssr_pvd_mode_t i_pvd_mode;
	int failures, n_tests, cyc, k, thr;
	logic exp_q[$];

	ssr_supply_model ssr_supply_model_i (.i_mv(mv), .i_press(press), .o_cmp(i_cmp),
		.o_ext_rst_n(i_ext_rst_n));
	ssr_supervisor #(.SETTLE_TICKS(2)) ssr_supervisor_i (.i_clk, .i_reset_n, .i_ls_clk,
		.i_has_bor, .i_cmp, .i_ext_rst_n, .i_src, .i_opt_load, .i_opt, .i_pvd_en, .i_pvd_lvl,
		.i_pvd_mode, .i_flag_clr, .o_sys_reset_n, .o_por_reset_n, .o_pvd_irq, .o_pvd_above,
		.o_rst_flags, .o_bor_cfg, .o_bor_active);

	initial
	begin
		i_clk = 0;
		forever #5 i_clk = ~i_clk;
	end
	initial
	begin
		i_ls_clk = 0;
		forever #100 i_ls_clk = ~i_ls_clk;
	end

	// ======================================================================
	// Tasks
	task automatic tick(int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask : tick
	task automatic chk1(logic got, logic exp);
		n_tests++;
		if (got !== exp)
		begin
			failures++;
			$display("[ERR] %0t bit %b expected %b", $time, got, exp);
		end
	endtask : chk1
	task automatic chk8(logic [7:0] got, logic [7:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			failures++;
			$display("[ERR] %0t value %h expected %h", $time, got, exp);
		end
	endtask : chk8
	task automatic wait_sys(logic v, int lim);
		for (int j = 0; j < lim && o_sys_reset_n !== v; j++)
			tick(1);
		chk1(o_sys_reset_n, v);
	endtask : wait_sys
	task automatic opt_load(logic dis, logic [2:0] l);
		i_opt = '{dis, l};
		i_opt_load = 1;
		tick(1);
		chk8({4'h0, o_bor_cfg}, {4'h0, dis, (l > 3'h4 ? 3'h4 : l)});
		i_opt_load = 0;
	endtask : opt_load
	task automatic print_verdict();
		if (failures == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : print_verdict

	// Interrupt watcher: oldest expectation against each pulse
	always @(posedge i_clk)
		if (i_reset_n && o_pvd_irq === 1'b1)
		begin
			if (exp_q.size() == 0)
			begin
				failures++;
				$display("[ERR] %0t unexpected interrupt", $time);
			end
			else
				chk1(o_pvd_above, exp_q.pop_front());
		end

	// Ceiling well above the expected run of under 1000 cycles
	always @(posedge i_clk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			failures++;
			print_verdict();
		end
	end

	// ======================================================================
	// Main sequence
	initial
	begin
		void'($urandom(32'hB80C));
		{i_reset_n, press, i_opt_load, i_pvd_en, i_flag_clr, i_src, i_opt, i_pvd_lvl} = '0;
		i_has_bor = 1;
		i_pvd_mode = PVD_EDGE_FALL;
		mv = 0;
		tick(20);
		chk8(o_rst_flags, 8'h80);
		i_reset_n = 1;
		mv = 1700;
		tick(40);
		chk1(o_por_reset_n, 0);
		mv = 3300;
		k = 0;
		while (o_por_reset_n !== 1'b1 && k < 200)
		begin
			tick(1);
			k++;
		end
		chk1(k >= 20 && k < 120, 1);
		wait_sys(1, 10);
		chk8(o_rst_flags, 8'h80);
		i_flag_clr = 1;
		tick(1);
		i_flag_clr = 0;
		tick(1);
		chk8(o_rst_flags, 8'h00);
		lv = 3'($urandom_range(3, 0));
		opt_load(0, lv);
		thr = 1800 + 200 * lv;
		mv = 16'(thr - 50);
		tick(20);
		chk1(o_sys_reset_n, 1);
		mv = 16'(thr - 150);
		wait_sys(0, 10);
		chk8({4'h0, o_bor_cfg}, 8'h04);
		mv = 1850;
		wait_sys(1, 100);
		mv = 3300;
		opt_load(1, 0);
		chk1(o_bor_active, 0);
		mv = 1600;
		tick(20);
		chk1(o_sys_reset_n, 1);
		mv = 1400;
		wait_sys(0, 10);
		mv = 3300;
		wait_sys(1, 100);
		// Part without a guard: power-up level releases, power-down level asserts
		i_has_bor = 0;
		mv = 1600;
		tick(20);
		chk1(o_sys_reset_n, 1);
		chk1(o_bor_active, 0);
		mv = 1400;
		wait_sys(0, 10);
		mv = 1600;
		wait_sys(1, 100);
		mv = 3300;
		tick(10);
		i_has_bor = 1;
		tick(2);
		chk1(o_bor_active, 1);
		for (int m = 0; m < 4; m++)
		begin
			// Level and mode change only while off, so no stale edge fires
			i_pvd_en = 0;
			i_pvd_lvl = 3'($urandom_range(6, 0));
			thr = 1850 + 200 * i_pvd_lvl;
			mv = 16'(thr - 40);
			i_pvd_mode = ssr_pvd_mode_t'(m);
			tick(10);
			i_pvd_en = 1;
			tick(2);
			mv = 16'(thr + 40);
			if (m == 1 || m == 2)
				exp_q.push_back(1);
			tick(10);
			chk1(o_pvd_above, 1);
			mv = 16'(thr - 40);
			if (m == 0 || m == 2)
				exp_q.push_back(0);
			tick(10);
			chk1(o_pvd_above, 0);
		end
		i_pvd_en = 0;
		mv = 3300;
		tick(10);
		chk1(o_pvd_above, 0);
		chk1(exp_q.size() == 0, 1);
		opt_load(0, 3'h7);
		i_flag_clr = 1;
		tick(1);
		i_flag_clr = 0;
		for (int b = 0; b < 7; b++)
		begin
			i_src = (b < 6) ? ssr_src_t'(6'h01 << b) : ssr_src_t'($urandom_range(63, 1));
			lv = 3'(b);
			tick(1);
			chk1(o_sys_reset_n, 0);
			chk8(o_rst_flags, {2'b00, i_src});
			i_src = '0;
			i_opt = '{1'b1, lv};
			i_opt_load = 1;
			tick(1);
			i_opt_load = 0;
			chk8({4'h0, o_bor_cfg}, 8'h04);
			wait_sys(1, 20);
			chk1(o_rst_flags == 8'h00, 0);
			i_flag_clr = 1;
			tick(1);
			i_flag_clr = 0;
		end
		press = 1;
		tick(6);
		press = 0;
		wait_sys(1, 20);
		chk8(o_rst_flags, 8'h40);
		print_verdict();
	end
endmodule : tb
